/* logic/host_irq_defines.vh */
`ifndef HOST_IRQ_DEFINES_VH
`define HOST_IRQ_DEFINES_VH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_IRQ_STATUS_AND_CONTROL 8'h14
`define OFS_TEST_CONFIG_ZERO       8'h18

// ************************************************************
// irq_status_and_control fields
// ************************************************************
`define IS_ABORT   7
`define IS_SWRST   6
`define IS_SIGNAL_PROCESS_FLAG    5
`define IS_SEM     4
`define IS_CONN    3
`define IS_FLY     2
`define IS_BUSIRQ  1
`define IS_DMAIRQ  0
`define IS_RESET   8'h00

// ************************************************************
// test_config_zero fields
// ************************************************************
`define TC_BURST_DIS 7
`define TC_SNOOP_HI  6
`define TC_SNOOP_LO  5
`define TC_REGEN_PAR 4
`define TC_FIFO_PAR  3
`define TC_EVEN_PAR  2
`define TC_XFER_TYPE 1
`define TC_LINE_MODE 0
`define TC_RESET     8'h00

// ************************************************************
// Bus modes and timing
// ************************************************************
`define BUS_MODE_1 2'h0
`define BUS_MODE_2 2'h1
`define BUS_MODE_3 2'h2
`define BUS_MODE_4 2'h3
`define BURST_BEATS 3'h4

`endif

/* logic/line_burst_seq.v */
`timescale 1ns/1ps
`include "host_irq_defines.vh"

module line_burst_seq (
	input  wire       clk,
	input  wire       rst,
	input  wire       kill,
	input  wire       start,
	input  wire       burst_ok,
	input  wire       ready,
	input  wire       inhibit,
	output reg        ads_n_q,
	output reg        breq_n_q,
	output reg        done_q,
	output reg        inhibited_q,
	output wire       busy
);

	// ************************************************************
	// One-hot sequencer
	// ************************************************************
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_ADDR = 3'b010;
	localparam [2:0] S_DATA = 3'b100;

	reg [2:0] state_q;
	reg [2:0] beats_q;
	reg       burst_q;

	assign busy = ~state_q[0];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q     <= S_IDLE;
			beats_q     <= 3'h0;
			burst_q     <= 1'b0;
			ads_n_q     <= 1'b1;
			breq_n_q    <= 1'b1;
			done_q      <= 1'b0;
			inhibited_q <= 1'b0;
		end else if (kill) begin
			state_q  <= S_IDLE;
			ads_n_q  <= 1'b1;
			breq_n_q <= 1'b1;
			done_q   <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (start) begin
						state_q  <= S_ADDR;
						ads_n_q  <= 1'b0;
						breq_n_q <= ~burst_ok;
						burst_q  <= burst_ok;
						beats_q  <= 3'h0;
						// A stale inhibit from an earlier line must not show on a single transfer
						inhibited_q <= 1'b0;
					end
				end
				S_ADDR: begin
					ads_n_q <= 1'b1;
					state_q <= S_DATA;
				end
				S_DATA: begin
					if (ready) begin
						beats_q <= beats_q + 3'h1;
						// Inhibit only counts at the first ready; later beats ignore it
						if (beats_q == 3'h0 && burst_q) begin
							inhibited_q <= inhibit;
						end
						if (!burst_q || (beats_q == 3'h0 && inhibit) ||
						    beats_q == `BURST_BEATS - 3'h1) begin
							state_q  <= S_IDLE;
							breq_n_q <= 1'b1;
							done_q   <= 1'b1;
						end
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

endmodule

/* logic/host_irq_status_and_test_ctl.v */
`timescale 1ns/1ps
`include "host_irq_defines.vh"

module host_irq_status_and_test_ctl (
	input  wire        CLK,
	input  wire        RST,
	input  wire [7:0]  REG_ADDR,
	input  wire        REG_WR,
	input  wire        REG_RD,
	input  wire [7:0]  REG_WDATA,
	output reg  [7:0]  REG_RDATA,
	output reg         REG_RPAR,
	input  wire [10:0] BUS_IRQ_EVENTS,
	input  wire        RD_BUS_CAUSE_A,
	input  wire        RD_BUS_CAUSE_B,
	input  wire [6:0]  DMA_IRQ_EVENTS,
	input  wire        RD_DMA_CAUSE,
	input  wire        RD_TEST_STATUS_TWO,
	input  wire        FLY_IRQ_INSTRUCTION,
	input  wire        SCRIPT_FLAG_WR,
	input  wire        SCRIPT_FLAG_VAL,
	input  wire        ARB_WON,
	input  wire        SEL_RESPONDED,
	input  wire        LINK_RELEASED,
	input  wire        WAIT_SEL_ACTIVE,
	input  wire        FIFO_POP,
	input  wire        FIFO_POP_PARITY,
	input  wire        PARITY_PASSTHRU,
	input  wire        BUS_MASTER,
	input  wire        SNOOP_PIN_MODE,
	input  wire        HOST_CYCLE_REQ,
	input  wire [1:0]  BUS_MODE,
	input  wire        LINE_XFER_START,
	input  wire        READY_IN_PIN_N,
	input  wire        BURST_INHIBIT_IN_N,
	output wire        ABORT_REQ,
	output wire        SOFT_RESET,
	output wire        BUS_SIGNALS_RELEASE,
	output wire        SIGNAL_PROCESS_FLAG,
	output reg         WAIT_SEL_JUMP,
	output wire        SCRIPT_HOST_FLAG,
	output wire        LINK_ATTACHED,
	output wire        BURST_DISABLE,
	output reg         SNOOP_HI_OUT,
	output reg         SNOOP_LO_OUT,
	output reg         SNOOP_OE_N,
	output wire        REGEN_RX_PARITY,
	output wire        FIFO_WR_PARITY,
	output wire        EVEN_PARITY_SELECT,
	output reg         XFER_TYPE_UPPER_PIN,
	output reg         XFER_TYPE_OE_N,
	output wire        ADDR_STROBE_PIN_N,
	output wire        BURST_REQUEST_OUT_N,
	output wire        LINE_XFER_DONE,
	output wire        BURST_INHIBITED
);

	// ************************************************************
	// Register state
	// ************************************************************
	reg       abort_q;
	reg       swrst_q;
	reg       signal_process_flag_q;
	reg       sem_q;
	reg       conn_q;
	reg       fly_q;
	reg       busirq_q;
	reg       dmairq_q;
	reg       cause_a_seen_q;
	reg       cause_b_seen_q;
	reg [7:0] tc0_q;
	reg       wait_sel_q;

	wire       wr_is = REG_WR && REG_ADDR == `OFS_IRQ_STATUS_AND_CONTROL;
	wire       wr_tc = REG_WR && REG_ADDR == `OFS_TEST_CONFIG_ZERO;
	wire [7:0] is_view = {abort_q, swrst_q, signal_process_flag_q, sem_q, conn_q, fly_q, busirq_q, dmairq_q};

	// ************************************************************
	// Interrupt status and control
	// ************************************************************
	// The register port never checks script state, so polling is
	// always safe and never stalls the script engine.
	wire bus_evt  = |BUS_IRQ_EVENTS;
	wire dma_evt  = |DMA_IRQ_EVENTS | abort_q;
	wire a_seen   = cause_a_seen_q | RD_BUS_CAUSE_A;
	wire b_seen   = cause_b_seen_q | RD_BUS_CAUSE_B;
	wire bus_clr  = a_seen & b_seen;

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			abort_q        <= 1'b0;
			swrst_q        <= 1'b0;
			signal_process_flag_q         <= 1'b0;
			sem_q          <= 1'b0;
			conn_q         <= 1'b0;
			fly_q          <= 1'b0;
			busirq_q       <= 1'b0;
			dmairq_q       <= 1'b0;
			cause_a_seen_q <= 1'b0;
			cause_b_seen_q <= 1'b0;
		end else begin
			// Software reset bit is only changed by the host or hardware reset
			if (wr_is) begin
				swrst_q <= REG_WDATA[`IS_SWRST];
			end
			if (swrst_q) begin
				// Everything else sits at its default while held
				abort_q        <= 1'b0;
				signal_process_flag_q         <= 1'b0;
				sem_q          <= 1'b0;
				conn_q         <= 1'b0;
				fly_q          <= 1'b0;
				busirq_q       <= 1'b0;
				dmairq_q       <= 1'b0;
				cause_a_seen_q <= 1'b0;
				cause_b_seen_q <= 1'b0;
			end else begin
				if (wr_is) begin
					abort_q <= REG_WDATA[`IS_ABORT];
				end
				// Host write beats a simultaneous test-status read clear
				if (wr_is) begin
					signal_process_flag_q <= REG_WDATA[`IS_SIGNAL_PROCESS_FLAG];
				end else if (RD_TEST_STATUS_TWO) begin
					signal_process_flag_q <= 1'b0;
				end
				if (SCRIPT_FLAG_WR) begin
					sem_q <= SCRIPT_FLAG_VAL;
				end else if (wr_is) begin
					sem_q <= REG_WDATA[`IS_SEM];
				end
				if (ARB_WON || SEL_RESPONDED) begin
					conn_q <= 1'b1;
				end else if (LINK_RELEASED) begin
					conn_q <= 1'b0;
				end
				if (FLY_IRQ_INSTRUCTION) begin
					fly_q <= 1'b1;
				end else if (wr_is && REG_WDATA[`IS_FLY]) begin
					fly_q <= 1'b0;
				end
				// Set beats clear on every hardware flag so stacked events survive
				if (bus_evt) begin
					busirq_q       <= 1'b1;
					cause_a_seen_q <= 1'b0;
					cause_b_seen_q <= 1'b0;
				end else if (bus_clr) begin
					busirq_q       <= 1'b0;
					cause_a_seen_q <= 1'b0;
					cause_b_seen_q <= 1'b0;
				end else begin
					cause_a_seen_q <= a_seen;
					cause_b_seen_q <= b_seen;
				end
				// Abort held high keeps re-raising the DMA flag after each read
				if (dma_evt) begin
					dmairq_q <= 1'b1;
				end else if (RD_DMA_CAUSE) begin
					dmairq_q <= 1'b0;
				end
			end
		end
	end

	assign ABORT_REQ           = abort_q;
	assign SOFT_RESET          = swrst_q;
	// Reset line itself is not driven; only the other bus signals drop
	assign BUS_SIGNALS_RELEASE = swrst_q;
	// The enable-ack, function-code and ID-mode bits live in the DMA
	// control register and must ignore SOFT_RESET there.
	assign SIGNAL_PROCESS_FLAG = signal_process_flag_q;
	assign SCRIPT_HOST_FLAG    = sem_q;
	assign LINK_ATTACHED       = conn_q;

	// ************************************************************
	// Wait-for-selection jump
	// ************************************************************
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			WAIT_SEL_JUMP <= 1'b0;
			wait_sel_q    <= 1'b0;
		end else begin
			wait_sel_q    <= WAIT_SEL_ACTIVE;
			// Pulses every other cycle while the wait stays active; the flag stays set for the script to test
			WAIT_SEL_JUMP <= WAIT_SEL_ACTIVE & signal_process_flag_q & ~swrst_q & ~WAIT_SEL_JUMP;
		end
	end

	// ************************************************************
	// Test configuration zero
	// ************************************************************
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			tc0_q <= `TC_RESET;
		end else if (swrst_q) begin
			tc0_q <= `TC_RESET;
		end else begin
			if (wr_tc) begin
				tc0_q <= REG_WDATA;
			end else if (FIFO_POP) begin
				tc0_q[`TC_FIFO_PAR] <= FIFO_POP_PARITY;
			end
		end
	end

	assign BURST_DISABLE      = tc0_q[`TC_BURST_DIS];
	assign REGEN_RX_PARITY    = tc0_q[`TC_REGEN_PAR] & PARITY_PASSTHRU;
	assign FIFO_WR_PARITY     = tc0_q[`TC_FIFO_PAR];
	assign EVEN_PARITY_SELECT = tc0_q[`TC_EVEN_PAR];

	// ************************************************************
	// Pins
	// ************************************************************
	wire line_mode = tc0_q[`TC_LINE_MODE];
	wire tt_drive  = BUS_MASTER && (BUS_MODE == `BUS_MODE_2 || BUS_MODE == `BUS_MODE_3 ||
	                 (BUS_MODE == `BUS_MODE_4 && !line_mode));

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			SNOOP_HI_OUT        <= 1'b0;
			SNOOP_LO_OUT        <= 1'b0;
			SNOOP_OE_N          <= 1'b1;
			XFER_TYPE_UPPER_PIN <= 1'b1;
			XFER_TYPE_OE_N      <= 1'b1;
		end else begin
			SNOOP_HI_OUT <= tc0_q[`TC_SNOOP_HI];
			if (SNOOP_PIN_MODE) begin
				SNOOP_LO_OUT <= HOST_CYCLE_REQ;
				SNOOP_OE_N   <= 1'b0;
			end else begin
				SNOOP_LO_OUT <= tc0_q[`TC_SNOOP_LO];
				SNOOP_OE_N   <= ~BUS_MASTER;
			end
			XFER_TYPE_UPPER_PIN <= ~tc0_q[`TC_XFER_TYPE];
			XFER_TYPE_OE_N      <= ~tt_drive;
		end
	end

	// ************************************************************
	// Cache line burst
	// ************************************************************
	// Ready and inhibit come from the host bus, which runs on CLK
	wire burst_ok = line_mode & ~tc0_q[`TC_BURST_DIS] & (BUS_MODE == `BUS_MODE_4);

	line_burst_seq u_burst (
		.clk         (CLK),
		.rst         (RST),
		.kill        (swrst_q | abort_q),
		.start       (LINE_XFER_START & BUS_MASTER),
		.burst_ok    (burst_ok),
		.ready       (~READY_IN_PIN_N),
		.inhibit     (~BURST_INHIBIT_IN_N),
		.ads_n_q     (ADDR_STROBE_PIN_N),
		.breq_n_q    (BURST_REQUEST_OUT_N),
		.done_q      (LINE_XFER_DONE),
		.inhibited_q (BURST_INHIBITED),
		.busy        ()
	);

	// ************************************************************
	// Read path
	// ************************************************************
	reg [7:0] rd_mux;

	always @* begin
		case (REG_ADDR)
			`OFS_IRQ_STATUS_AND_CONTROL: rd_mux = is_view;
			`OFS_TEST_CONFIG_ZERO:       rd_mux = tc0_q;
			default:                     rd_mux = 8'h00;
		endcase
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			REG_RDATA <= 8'h00;
			REG_RPAR  <= 1'b1;
		end else if (REG_RD) begin
			REG_RDATA <= rd_mux;
			// Odd parity by default; even select flips the generated bit
			REG_RPAR  <= ~(^rd_mux) ^ tc0_q[`TC_EVEN_PAR];
		end
	end

endmodule

/* dv/host_irq_status_and_test_ctl_checker.sv */
`timescale 1ns/1ps
module host_irq_status_and_test_ctl_checker (
	input wire       CLK,
	input wire       RST,
	input wire [7:0] REG_ADDR,
	input wire       REG_WR,
	input wire       REG_RD,
	input wire [7:0] REG_WDATA,
	input wire [7:0] REG_RDATA,
	input wire       REG_RPAR,
	input wire       RD_TEST_STATUS_TWO,
	input wire       ARB_WON,
	input wire       SEL_RESPONDED,
	input wire       WAIT_SEL_ACTIVE,
	input wire       PARITY_PASSTHRU,
	input wire       BUS_MASTER,
	input wire       SNOOP_PIN_MODE,
	input wire [1:0] BUS_MODE,
	input wire       ABORT_REQ,
	input wire       SOFT_RESET,
	input wire       BUS_SIGNALS_RELEASE,
	input wire       SIGNAL_PROCESS_FLAG,
	input wire       WAIT_SEL_JUMP,
	input wire       LINK_ATTACHED,
	input wire       BURST_DISABLE,
	input wire       SNOOP_OE_N,
	input wire       REGEN_RX_PARITY,
	input wire       EVEN_PARITY_SELECT,
	input wire       XFER_TYPE_OE_N,
	input wire       ADDR_STROBE_PIN_N
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// ****************
	// Sequences
	// ****************
	sequence s_strobe;
		$fell(ADDR_STROBE_PIN_N);
	endsequence
	sequence s_wait_signal_process_flag;
		(WAIT_SEL_ACTIVE && SIGNAL_PROCESS_FLAG)[*2];
	endsequence
	// ****************
	// Assertions
	// ****************
	a_abort_sets_req: assert property (REG_WR && REG_ADDR == 8'h14 && REG_WDATA[7] && !REG_WDATA[6] && !SOFT_RESET
		|=> ABORT_REQ) else $error("abort write not seen on abort request");
	a_swrst_clears: assert property (SOFT_RESET && !REG_WR
		|=> !ABORT_REQ && !SIGNAL_PROCESS_FLAG && !BURST_DISABLE) else $error("bits survive software reset");
	a_release_tracks: assert property (BUS_SIGNALS_RELEASE == SOFT_RESET) else $error("release not tied to reset");
	a_signal_process_flag_read_clr: assert property (RD_TEST_STATUS_TWO && !REG_WR |=> !SIGNAL_PROCESS_FLAG)
		else $error("signal flag kept after test read");
	a_wait_jump: assert property (s_wait_signal_process_flag |=> WAIT_SEL_JUMP || $past(WAIT_SEL_JUMP))
		else $error("no jump while waiting with signal flag");
	a_connect_set: assert property ((ARB_WON || SEL_RESPONDED) && !SOFT_RESET |=> LINK_ATTACHED)
		else $error("connected flag not set");
	a_regen_gate: assert property (REGEN_RX_PARITY |-> PARITY_PASSTHRU) else $error("regen outside pass-through");
	a_snoop_drive: assert property (BUS_MASTER && !SNOOP_PIN_MODE |=> !SNOOP_OE_N)
		else $error("snoop pins not driven as master");
	a_xfer_type_drive: assert property (BUS_MASTER && (BUS_MODE == 2'h1 || BUS_MODE == 2'h2) |=> !XFER_TYPE_OE_N)
		else $error("transfer type pin not driven");
	a_read_parity: assert property (REG_RD |=> REG_RPAR == (~^REG_RDATA ^ $past(EVEN_PARITY_SELECT)))
		else $error("read parity sense wrong");
	a_strobe_pulse: assert property (s_strobe |=> ADDR_STROBE_PIN_N[*2]) else $error("strobe not one cycle");
endmodule

bind host_irq_status_and_test_ctl host_irq_status_and_test_ctl_checker i_host_irq_status_and_test_ctl_checker (
	.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
	.REG_RDATA(REG_RDATA), .REG_RPAR(REG_RPAR), .RD_TEST_STATUS_TWO(RD_TEST_STATUS_TWO), .ARB_WON(ARB_WON),
	.SEL_RESPONDED(SEL_RESPONDED), .WAIT_SEL_ACTIVE(WAIT_SEL_ACTIVE), .PARITY_PASSTHRU(PARITY_PASSTHRU),
	.BUS_MASTER(BUS_MASTER), .SNOOP_PIN_MODE(SNOOP_PIN_MODE), .BUS_MODE(BUS_MODE), .ABORT_REQ(ABORT_REQ),
	.SOFT_RESET(SOFT_RESET), .BUS_SIGNALS_RELEASE(BUS_SIGNALS_RELEASE), .SIGNAL_PROCESS_FLAG(SIGNAL_PROCESS_FLAG),
	.WAIT_SEL_JUMP(WAIT_SEL_JUMP), .LINK_ATTACHED(LINK_ATTACHED), .BURST_DISABLE(BURST_DISABLE),
	.SNOOP_OE_N(SNOOP_OE_N), .REGEN_RX_PARITY(REGEN_RX_PARITY), .EVEN_PARITY_SELECT(EVEN_PARITY_SELECT),
	.XFER_TYPE_OE_N(XFER_TYPE_OE_N), .ADDR_STROBE_PIN_N(ADDR_STROBE_PIN_N));

/* dv/host_cpu_model.sv */
`timescale 1ns/1ps
module host_cpu_model (
	input  wire       clk,
	output reg  [7:0] addr,
	output reg        wr,
	output reg        rd,
	output reg  [7:0] wdata,
	input  wire [7:0] rdata
);
	initial {addr, wr, rd, wdata} = '0;
	// Idle bus changes every access so stale values cannot pass
	task idle;
		begin
			{wr, rd} = 2'h0;
			addr = ~addr;
			wdata = ~wdata;
		end
	endtask
	task reg_wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge clk);
			{addr, wdata, wr} = {a, d, 1'h1};
			@(negedge clk);
			idle;
		end
	endtask
	task reg_rd(input [7:0] a, output [7:0] d);
		begin
			@(negedge clk);
			{addr, rd} = {a, 1'h1};
			@(negedge clk);
			idle;
			d = rdata;
		end
	endtask
endmodule

/* dv/host_irq_status_and_test_ctl_tb.sv */
`timescale 1ns/1ps
module host_irq_status_and_test_ctl_tb;
	// ****************
	// Signals
	// ****************
	reg        CLK, RST, RD_BUS_CAUSE_A, RD_BUS_CAUSE_B, RD_DMA_CAUSE, RD_TEST_STATUS_TWO, FLY_IRQ_INSTRUCTION;
	reg        SCRIPT_FLAG_WR, SCRIPT_FLAG_VAL, ARB_WON, SEL_RESPONDED, LINK_RELEASED, WAIT_SEL_ACTIVE, FIFO_POP;
	reg        FIFO_POP_PARITY, PARITY_PASSTHRU, BUS_MASTER, SNOOP_PIN_MODE, HOST_CYCLE_REQ, LINE_XFER_START;
	reg        READY_IN_PIN_N, BURST_INHIBIT_IN_N;
	reg [10:0] BUS_IRQ_EVENTS;
	reg [6:0]  DMA_IRQ_EVENTS;
	reg [1:0]  BUS_MODE;
	reg [7:0]  v;
	wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
	wire       REG_WR, REG_RD, ABORT_REQ, SOFT_RESET, BUS_SIGNALS_RELEASE, SIGNAL_PROCESS_FLAG, WAIT_SEL_JUMP;
	wire       SCRIPT_HOST_FLAG, LINK_ATTACHED, BURST_DISABLE, SNOOP_HI_OUT, SNOOP_LO_OUT, SNOOP_OE_N;
	wire       REGEN_RX_PARITY, FIFO_WR_PARITY, EVEN_PARITY_SELECT, XFER_TYPE_UPPER_PIN, XFER_TYPE_OE_N;
	wire       ADDR_STROBE_PIN_N, BURST_REQUEST_OUT_N, LINE_XFER_DONE, BURST_INHIBITED;
	integer    miscompares, n_tests, i, j, k;

	host_cpu_model i_host_cpu_model (.clk(CLK), .addr(REG_ADDR), .wr(REG_WR), .rd(REG_RD), .wdata(REG_WDATA),
		.rdata(REG_RDATA));
	host_irq_status_and_test_ctl i_host_irq_status_and_test_ctl (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RPAR(),
		.BUS_IRQ_EVENTS(BUS_IRQ_EVENTS), .RD_BUS_CAUSE_A(RD_BUS_CAUSE_A), .RD_BUS_CAUSE_B(RD_BUS_CAUSE_B),
		.DMA_IRQ_EVENTS(DMA_IRQ_EVENTS), .RD_DMA_CAUSE(RD_DMA_CAUSE), .RD_TEST_STATUS_TWO(RD_TEST_STATUS_TWO),
		.FLY_IRQ_INSTRUCTION(FLY_IRQ_INSTRUCTION), .SCRIPT_FLAG_WR(SCRIPT_FLAG_WR), .SCRIPT_FLAG_VAL(SCRIPT_FLAG_VAL),
		.ARB_WON(ARB_WON), .SEL_RESPONDED(SEL_RESPONDED), .LINK_RELEASED(LINK_RELEASED),
		.WAIT_SEL_ACTIVE(WAIT_SEL_ACTIVE), .FIFO_POP(FIFO_POP), .FIFO_POP_PARITY(FIFO_POP_PARITY),
		.PARITY_PASSTHRU(PARITY_PASSTHRU), .BUS_MASTER(BUS_MASTER), .SNOOP_PIN_MODE(SNOOP_PIN_MODE),
		.HOST_CYCLE_REQ(HOST_CYCLE_REQ), .BUS_MODE(BUS_MODE), .LINE_XFER_START(LINE_XFER_START),
		.READY_IN_PIN_N(READY_IN_PIN_N), .BURST_INHIBIT_IN_N(BURST_INHIBIT_IN_N), .ABORT_REQ(ABORT_REQ),
		.SOFT_RESET(SOFT_RESET), .BUS_SIGNALS_RELEASE(BUS_SIGNALS_RELEASE), .SIGNAL_PROCESS_FLAG(SIGNAL_PROCESS_FLAG),
		.WAIT_SEL_JUMP(WAIT_SEL_JUMP), .SCRIPT_HOST_FLAG(SCRIPT_HOST_FLAG), .LINK_ATTACHED(LINK_ATTACHED),
		.BURST_DISABLE(BURST_DISABLE), .SNOOP_HI_OUT(SNOOP_HI_OUT), .SNOOP_LO_OUT(SNOOP_LO_OUT),
		.SNOOP_OE_N(SNOOP_OE_N), .REGEN_RX_PARITY(REGEN_RX_PARITY), .FIFO_WR_PARITY(FIFO_WR_PARITY),
		.EVEN_PARITY_SELECT(EVEN_PARITY_SELECT), .XFER_TYPE_UPPER_PIN(XFER_TYPE_UPPER_PIN),
		.XFER_TYPE_OE_N(XFER_TYPE_OE_N), .ADDR_STROBE_PIN_N(ADDR_STROBE_PIN_N),
		.BURST_REQUEST_OUT_N(BURST_REQUEST_OUT_N), .LINE_XFER_DONE(LINE_XFER_DONE), .BURST_INHIBITED(BURST_INHIBITED));

	always #20 CLK = ~CLK;
	// ****************
	// Tasks
	// ****************
	task chk(input [7:0] seen, input [7:0] exp, input [8*10-1:0] name);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("Error %0s: expected %h, seen %h", name, exp, seen);
			end
		end
	endtask
	task rchk(input [7:0] a, input [7:0] e);
		begin
			i_host_cpu_model.reg_rd(a, v);
			chk(v, e, "register");
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		i_host_cpu_model.reg_wr(a, d);
	endtask
	task end_sim;
		begin
			$display("Comparisons %0d, miscompares %0d", n_tests, miscompares);
			if (miscompares == 0 && n_tests > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	// Whole run is well under 3000 cycles
	initial begin
		#200000;
		miscompares = miscompares + 1;
		end_sim;
	end
	// ****************
	// Tests
	// ****************
	initial begin
		{RD_BUS_CAUSE_A, RD_BUS_CAUSE_B, RD_DMA_CAUSE, RD_TEST_STATUS_TWO, FLY_IRQ_INSTRUCTION, SCRIPT_FLAG_WR} = '0;
		{SCRIPT_FLAG_VAL, ARB_WON, SEL_RESPONDED, LINK_RELEASED, WAIT_SEL_ACTIVE, FIFO_POP, FIFO_POP_PARITY} = '0;
		{PARITY_PASSTHRU, BUS_MASTER, SNOOP_PIN_MODE, HOST_CYCLE_REQ, LINE_XFER_START, BUS_MODE} = '0;
		{BUS_IRQ_EVENTS, DMA_IRQ_EVENTS, CLK} = '0;
		{RST, READY_IN_PIN_N, BURST_INHIBIT_IN_N} = 3'h7;
		{miscompares, n_tests} = '0;
		repeat (4) @(negedge CLK);
		RST = 1'h0;
		rchk(8'h14, 8'h00);
		rchk(8'h18, 8'h00);
		rchk(8'h20, 8'h00);
		wr(8'h18, 8'hF4);
		rchk(8'h18, 8'hF4);
		chk({BURST_DISABLE, EVEN_PARITY_SELECT, REGEN_RX_PARITY}, 8'h06, "cfg pins");
		{PARITY_PASSTHRU, BUS_MASTER, BUS_MODE} = 4'hD;
		@(negedge CLK);
		@(negedge CLK);
		chk({REGEN_RX_PARITY, SNOOP_OE_N, SNOOP_HI_OUT, SNOOP_LO_OUT}, 8'h0B, "snoop");
		chk({XFER_TYPE_OE_N, XFER_TYPE_UPPER_PIN}, 8'h01, "xfer type");
		{SNOOP_PIN_MODE, BUS_MASTER, FIFO_POP, FIFO_POP_PARITY} = 4'hB;
		@(negedge CLK) FIFO_POP = 1'h0;
		@(negedge CLK);
		chk({SNOOP_HI_OUT, SNOOP_LO_OUT, FIFO_WR_PARITY}, 8'h05, "pin mode");
		rchk(8'h18, 8'hFC);
		wr(8'h14, 8'h30);
		rchk(8'h14, 8'h30);
		chk({SIGNAL_PROCESS_FLAG, SCRIPT_HOST_FLAG}, 8'h03, "flags");
		WAIT_SEL_ACTIVE = 1'h1;
		k = 0;
		repeat (4) @(negedge CLK) k = k + WAIT_SEL_JUMP;
		WAIT_SEL_ACTIVE = 1'h0;
		chk(k, 2, "jumps");
		@(negedge CLK) RD_TEST_STATUS_TWO = 1'h1;
		@(negedge CLK) {RD_TEST_STATUS_TWO, SCRIPT_FLAG_WR} = 2'h1;
		@(negedge CLK) SCRIPT_FLAG_WR = 1'h0;
		rchk(8'h14, 8'h00);
		@(negedge CLK) ARB_WON = 1'h1;
		@(negedge CLK) {ARB_WON, FLY_IRQ_INSTRUCTION} = 2'h1;
		@(negedge CLK) FLY_IRQ_INSTRUCTION = 1'h0;
		rchk(8'h14, 8'h0C);
		wr(8'h14, 8'h00);
		rchk(8'h14, 8'h0C);
		wr(8'h14, 8'h04);
		@(negedge CLK) LINK_RELEASED = 1'h1;
		@(negedge CLK) LINK_RELEASED = 1'h0;
		rchk(8'h14, 8'h00);
		@(negedge CLK) SEL_RESPONDED = 1'h1;
		@(negedge CLK) SEL_RESPONDED = 1'h0;
		rchk(8'h14, 8'h08);
		for (i = 0; i < 11; i = i + 1) begin
			@(negedge CLK) BUS_IRQ_EVENTS = 11'h001 << i;
			@(negedge CLK) {BUS_IRQ_EVENTS, RD_BUS_CAUSE_B} = 12'h001;
			@(negedge CLK) RD_BUS_CAUSE_B = 1'h0;
			rchk(8'h14, 8'h0A);
			@(negedge CLK) RD_BUS_CAUSE_A = 1'h1;
			@(negedge CLK) RD_BUS_CAUSE_A = 1'h0;
			rchk(8'h14, 8'h08);
		end
		for (i = 0; i < 7; i = i + 1) begin
			@(negedge CLK) DMA_IRQ_EVENTS = 7'h01 << i;
			@(negedge CLK) DMA_IRQ_EVENTS = 7'h00;
			rchk(8'h14, 8'h09);
			@(negedge CLK) RD_DMA_CAUSE = 1'h1;
			@(negedge CLK) RD_DMA_CAUSE = 1'h0;
			rchk(8'h14, 8'h08);
		end
		wr(8'h14, 8'h80);
		chk(ABORT_REQ, 1, "abort");
		rchk(8'h14, 8'h89);
		wr(8'h14, 8'h00);
		@(negedge CLK) RD_DMA_CAUSE = 1'h1;
		@(negedge CLK) RD_DMA_CAUSE = 1'h0;
		rchk(8'h14, 8'h08);
		wr(8'h18, 8'h01);
		wr(8'h14, 8'hF0);
		rchk(8'h14, 8'h40);
		rchk(8'h18, 8'h00);
		chk({SOFT_RESET, BUS_SIGNALS_RELEASE}, 8'h03, "swreset");
		wr(8'h14, 8'h00);
		rchk(8'h14, 8'h00);
		{BUS_MASTER, BUS_MODE} = 3'h7;
		for (j = 0; j < 3; j = j + 1) begin
			wr(8'h18, j == 2 ? 8'h81 : 8'h01);
			BURST_INHIBIT_IN_N = (j != 1);
			@(negedge CLK) LINE_XFER_START = 1'h1;
			@(negedge CLK) LINE_XFER_START = 1'h0;
			chk({ADDR_STROBE_PIN_N, BURST_REQUEST_OUT_N}, j == 2, "request");
			k = -1;
			for (i = 0; i < 10; i = i + 1) begin
				// Ready is held off during the address cycle, then asserted for four beats
				READY_IN_PIN_N = (i == 0 || i > 4);
				@(negedge CLK);
				if (LINE_XFER_DONE === 1'h1 && k < 0)
					k = i;
			end
			chk(k >= (j == 0 ? 4 : 1) && k <= (j == 0 ? 5 : 2), 1, "beats");
			chk(BURST_INHIBITED, j == 1, "inhibit");
		end
		// Hardware reset in mid-run must drop line mode as well
		wr(8'h18, 8'h01);
		@(negedge CLK) RST = 1'h1;
		@(negedge CLK) RST = 1'h0;
		rchk(8'h18, 8'h00);
		end_sim;
	end
endmodule
